/* rtl/adc_calib_standby_cmd_regs.sv */
// command interpreter and configuration registers of a delta-sigma converter
// assumes: serial clock, chip select and data-in come from the host pins;
// register framing, data readout and the calibration engine are neighbours
// on sys_clk_i (the master clock), which talk through the plain ports below.
`timescale 1ns/1ns
`default_nettype none
`include "adc_cmd_defs.svh"

// Summary of operation
// - internal gain cal updates gain coefficients
// - external offset cal updates offset coefficients
// - external gain cal updates gain coefficients
// - ready high during cal, low after settle
// - standby left on serial clock with select
// - select high: clock ignored, standby kept
// - resume command ends standby, conversions restart
// - standby plus resume gives single conversion
// - reset command restores defaults, keeps clock-rate bits
// - reset command ends continuous read mode
// - sync then resume restarts on first edge
// - eleven byte registers at 00h to 0Ah
// - status identity bits read-only, writes ignored
// - input MSB first; status bit 3 output order
// - auto-calibrate after writes changing gain, rate, buffer
// - buffer enable, forced by sensor current
// - status bit 0 mirrors ready output
// - FCh decodes as synchronize
// - FEh decodes as register reset
// - these commands are single standalone bytes
module adc_calib_standby_cmd_regs #(
	parameter logic [3:0] FACTORY_ID = 4'h5 // arbitrary value
) (
	input  wire logic                      sys_clk_i,
	input  wire logic                      resetn_i,
	input  wire logic                      sclk_i,
	input  wire logic                      cs_n_i,
	input  wire logic                      din_i,
	input  wire logic                      frame_busy_i,
	input  wire logic                      reg_wr_i,
	input  wire logic [3:0]                reg_addr_i,
	input  wire logic [7:0]                reg_wdata_i,
	input  wire logic                      reg_wr_last_i,
	input  wire logic [3:0]                reg_rd_addr_i,
	input  wire logic                      conv_done_i,
	input  wire logic                      data_read_i,
	input  wire logic                      cal_done_i,
	input  wire logic [23:0]               cal_offset_i,
	input  wire logic [23:0]               cal_gain_i,
	output logic [7:0]                     reg_rdata_o,
	output logic                           conversion_ready_n_o,
	output logic                           cal_start_o,
	output adc_cmd_pkg::cal_kind_t         cal_kind_o,
	output logic                           conv_restart_o,
	output logic                           converter_enable_o,
	output logic                           standby_o,
	output logic                           cont_read_stop_o,
	output logic                           lsb_first_o,
	output logic                           input_buffer_on_o,
	output logic [1:0]                     clock_out_rate_o
);
	if (FACTORY_ID > 4'hF)
	begin : g_bad_id
		$error("factory identity does not fit four bits");
	end
	// link domain: clears while select is high, so stray clocks are ignored
	logic       link_clr_n;
	logic [2:0] bit_cnt;
	logic [6:0] shifter;
	logic [7:0] byte_hold;
	logic       byte_tgl;
	logic       edge_tgl;
	assign link_clr_n = resetn_i & ~cs_n_i;
	always_ff @(posedge sclk_i or negedge link_clr_n)
	begin
		if (!link_clr_n)
		begin
			bit_cnt <= 3'h0;
			shifter <= 7'h00;
		end
		else
		begin
			bit_cnt <= bit_cnt + 3'h1;
			shifter <= {shifter[5:0], din_i};
		end
	end
	// byte and first-edge events cross as toggles; byte_hold stays stable
	// for a whole byte time, far longer than the three-flop crossing
	always_ff @(posedge sclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			byte_hold <= 8'h00;
			byte_tgl  <= 1'b0;
			edge_tgl  <= 1'b0;
		end
		else if (!cs_n_i)
		begin
			if (bit_cnt == 3'h7)
			begin
				byte_hold <= {shifter, din_i};
				byte_tgl  <= ~byte_tgl;
			end
			if (bit_cnt == 3'h0)
				edge_tgl <= ~edge_tgl;
		end
	end
	// system domain
	logic [2:0] byte_sync;
	logic [2:0] edge_sync;
	logic       byte_evt;
	logic       edge_evt;
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			byte_sync <= 3'h0;
			edge_sync <= 3'h0;
		end
		else
		begin
			byte_sync <= {byte_sync[1:0], byte_tgl};
			edge_sync <= {edge_sync[1:0], edge_tgl};
		end
	end
	assign byte_evt = byte_sync[2] ^ byte_sync[1];
	assign edge_evt = edge_sync[2] ^ edge_sync[1];
	adc_cmd_pkg::mode_t mode;
	adc_cmd_pkg::mode_t next_mode;
	logic               cmd_take;
	logic               cal_cmd;
	logic               auto_calibrate_en_go;
	adc_cmd_pkg::cal_kind_t next_kind;
	logic [7:0]         cmd;
	logic [7:0]  status_config;
	logic [7:0]  input_select;
	logic [7:0]  converter_control;
	logic [7:0]  rate_select;
	logic [7:0]  pin_io_control;
	logic [23:0] offset_coefficient;
	logic [23:0] full_scale_coefficient;
	logic        auto_calibrate_en_pend;
	// frame_busy_i covers data bytes of multi-byte commands
	assign cmd      = byte_hold;
	assign cmd_take = byte_evt && !frame_busy_i && (mode == adc_cmd_pkg::MODE_RUN);
	assign auto_calibrate_en_go  = reg_wr_last_i && auto_calibrate_en_pend && status_config[`STATUS_AUTO_CALIBRATE_EN_BIT]
		&& (mode == adc_cmd_pkg::MODE_RUN);
	always_comb
	begin
		cal_cmd   = cmd_take;
		next_kind = adc_cmd_pkg::CAL_SELF_BOTH;
		case (cmd)
			`CMD_SELF_CAL:          next_kind = adc_cmd_pkg::CAL_SELF_BOTH;
			`CMD_SELF_OFFSET_CAL:   next_kind = adc_cmd_pkg::CAL_SELF_OFFSET;
			`CMD_INTERNAL_GAIN_CAL: next_kind = adc_cmd_pkg::CAL_INTERNAL_GAIN;
			`CMD_EXTERNAL_OFS_CAL:  next_kind = adc_cmd_pkg::CAL_EXTERNAL_OFFSET;
			`CMD_EXTERNAL_GAIN_CAL: next_kind = adc_cmd_pkg::CAL_EXTERNAL_GAIN;
			default:                cal_cmd = 1'b0;
		endcase
		if (auto_calibrate_en_go && !cal_cmd)
		begin
			cal_cmd   = 1'b1;
			next_kind = adc_cmd_pkg::CAL_SELF_BOTH;
		end
	end
	always_comb
	begin
		next_mode = mode;
		case (mode)
			adc_cmd_pkg::MODE_RUN:
			begin
				if (cal_cmd)
					next_mode = adc_cmd_pkg::MODE_CAL_RUN;
				else if (cmd_take && cmd == `CMD_STANDBY)
					next_mode = adc_cmd_pkg::MODE_STANDBY;
				else if (cmd_take && cmd == `CMD_SYNC)
					next_mode = adc_cmd_pkg::MODE_SYNC_WAIT;
			end
			adc_cmd_pkg::MODE_CAL_RUN:
				if (cal_done_i)
					next_mode = adc_cmd_pkg::MODE_CAL_SETTLE;
			adc_cmd_pkg::MODE_CAL_SETTLE:
				if (conv_done_i)
					next_mode = adc_cmd_pkg::MODE_RUN;
			adc_cmd_pkg::MODE_STANDBY, adc_cmd_pkg::MODE_SYNC_WAIT:
				if (edge_evt)
					next_mode = adc_cmd_pkg::MODE_RUN;
			default:
				next_mode = adc_cmd_pkg::MODE_RUN;
		endcase
	end
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			mode <= adc_cmd_pkg::MODE_RUN;
		else
			mode <= next_mode;
	end
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cal_start_o        <= 1'b0;
			cal_kind_o         <= adc_cmd_pkg::CAL_SELF_BOTH;
			conv_restart_o     <= 1'b0;
			cont_read_stop_o   <= 1'b0;
			standby_o          <= 1'b0;
			converter_enable_o <= 1'b1;
		end
		else
		begin
			cal_start_o <= cal_cmd && (mode == adc_cmd_pkg::MODE_RUN);
			if (cal_cmd && (mode == adc_cmd_pkg::MODE_RUN))
				cal_kind_o <= next_kind;
			// single shot: resume restarts one conversion, standby may follow
			conv_restart_o <= edge_evt && ((mode == adc_cmd_pkg::MODE_STANDBY)
				|| (mode == adc_cmd_pkg::MODE_SYNC_WAIT));
			cont_read_stop_o <= cmd_take && (cmd == `CMD_REG_RESET);
			standby_o <= (mode == adc_cmd_pkg::MODE_STANDBY);
			converter_enable_o <= (mode != adc_cmd_pkg::MODE_STANDBY)
				&& (mode != adc_cmd_pkg::MODE_SYNC_WAIT);
		end
	end
	// ready: set wins over clear when a calibration starts on a data-ready
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			conversion_ready_n_o <= 1'b1;
		else if (cal_cmd && (mode == adc_cmd_pkg::MODE_RUN))
			conversion_ready_n_o <= 1'b1;
		else if (mode == adc_cmd_pkg::MODE_CAL_RUN)
			conversion_ready_n_o <= 1'b1;
		else if (conv_done_i && ((mode == adc_cmd_pkg::MODE_RUN)
			|| (mode == adc_cmd_pkg::MODE_CAL_SETTLE)))
			conversion_ready_n_o <= 1'b0;
		else if (data_read_i)
			conversion_ready_n_o <= 1'b1;
	end
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wdata,
		input logic [7:0] wmask);
		merge = (old & ~wmask) | (wdata & wmask);
	endfunction
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			status_config          <= `STATUS_RST;
			input_select           <= `INPUT_SELECT_RST;
			converter_control      <= `CONV_CTRL_RST;
			rate_select            <= `RATE_SELECT_RST;
			pin_io_control         <= `PIN_IO_RST;
			offset_coefficient     <= `COEF_RST;
			full_scale_coefficient <= `COEF_RST;
		end
		else if (cmd_take && cmd == `CMD_REG_RESET)
		begin
			status_config     <= `STATUS_RST;
			input_select      <= `INPUT_SELECT_RST;
			converter_control <= merge(`CONV_CTRL_RST, converter_control,
				`CONV_CTRL_CLK_MASK);
			rate_select            <= `RATE_SELECT_RST;
			pin_io_control         <= `PIN_IO_RST;
			offset_coefficient     <= `COEF_RST;
			full_scale_coefficient <= `COEF_RST;
		end
		else if (cal_done_i && mode == adc_cmd_pkg::MODE_CAL_RUN)
		begin
			if (cal_kind_o == adc_cmd_pkg::CAL_SELF_BOTH
				|| cal_kind_o == adc_cmd_pkg::CAL_SELF_OFFSET
				|| cal_kind_o == adc_cmd_pkg::CAL_EXTERNAL_OFFSET)
				offset_coefficient <= cal_offset_i;
			if (cal_kind_o == adc_cmd_pkg::CAL_SELF_BOTH
				|| cal_kind_o == adc_cmd_pkg::CAL_INTERNAL_GAIN
				|| cal_kind_o == adc_cmd_pkg::CAL_EXTERNAL_GAIN)
				full_scale_coefficient <= cal_gain_i;
		end
		else if (reg_wr_i)
		begin
			case (reg_addr_i)
				`ADDR_STATUS_CONFIG:
					status_config <= merge(status_config, reg_wdata_i, `STATUS_WMASK);
				`ADDR_INPUT_SELECT:     input_select <= reg_wdata_i;
				`ADDR_CONVERTER_CTRL:
					converter_control <= merge(converter_control, reg_wdata_i,
						`CONV_CTRL_WMASK);
				`ADDR_RATE_SELECT:      rate_select <= reg_wdata_i;
				`ADDR_PIN_IO_CONTROL:
					pin_io_control <= merge(pin_io_control, reg_wdata_i, `PIN_IO_WMASK);
				`ADDR_OFFSET_COEF_LOW:  offset_coefficient[7:0] <= reg_wdata_i;
				`ADDR_OFFSET_COEF_MID:  offset_coefficient[15:8] <= reg_wdata_i;
				`ADDR_OFFSET_COEF_HIGH: offset_coefficient[23:16] <= reg_wdata_i;
				`ADDR_GAIN_COEF_LOW:    full_scale_coefficient[7:0] <= reg_wdata_i;
				`ADDR_GAIN_COEF_MID:    full_scale_coefficient[15:8] <= reg_wdata_i;
				`ADDR_GAIN_COEF_HIGH:   full_scale_coefficient[23:16] <= reg_wdata_i;
				default:                input_select <= input_select;
			endcase
		end
	end
	// remembers a settings change inside one write frame; reset command drops it
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			auto_calibrate_en_pend <= 1'b0;
		else if (reg_wr_i && ((reg_addr_i == `ADDR_RATE_SELECT && reg_wdata_i != rate_select)
			|| (reg_addr_i == `ADDR_CONVERTER_CTRL
				&& reg_wdata_i[`CONV_CTRL_GAIN_MSB:`CONV_CTRL_GAIN_LSB]
				!= converter_control[`CONV_CTRL_GAIN_MSB:`CONV_CTRL_GAIN_LSB])
			|| (reg_addr_i == `ADDR_STATUS_CONFIG
				&& reg_wdata_i[`STATUS_INPUT_BUFFER_EN_BIT] != status_config[`STATUS_INPUT_BUFFER_EN_BIT])))
			auto_calibrate_en_pend <= 1'b1;
		else if (reg_wr_last_i || (cmd_take && cmd == `CMD_REG_RESET))
			auto_calibrate_en_pend <= 1'b0;
	end
	function automatic logic [7:0] read_reg(input logic [3:0] addr);
		case (addr)
			`ADDR_STATUS_CONFIG:
				read_reg = {FACTORY_ID, status_config[3:1], conversion_ready_n_o};
			`ADDR_INPUT_SELECT:     read_reg = input_select;
			`ADDR_CONVERTER_CTRL:   read_reg = converter_control;
			`ADDR_RATE_SELECT:      read_reg = rate_select;
			`ADDR_PIN_IO_CONTROL:   read_reg = pin_io_control | `PIN_IO_FIXED;
			`ADDR_OFFSET_COEF_LOW:  read_reg = offset_coefficient[7:0];
			`ADDR_OFFSET_COEF_MID:  read_reg = offset_coefficient[15:8];
			`ADDR_OFFSET_COEF_HIGH: read_reg = offset_coefficient[23:16];
			`ADDR_GAIN_COEF_LOW:    read_reg = full_scale_coefficient[7:0];
			`ADDR_GAIN_COEF_MID:    read_reg = full_scale_coefficient[15:8];
			`ADDR_GAIN_COEF_HIGH:   read_reg = full_scale_coefficient[23:16];
			default:                read_reg = 8'h00;
		endcase
	endfunction
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			reg_rdata_o       <= 8'h00;
			lsb_first_o       <= 1'b0;
			input_buffer_on_o <= 1'b0;
			clock_out_rate_o  <= 2'h1;
		end
		else
		begin
			reg_rdata_o <= read_reg(reg_rd_addr_i);
			lsb_first_o <= status_config[`STATUS_ORDER_BIT];
			input_buffer_on_o <= status_config[`STATUS_INPUT_BUFFER_EN_BIT]
				| (|converter_control[`CONV_CTRL_SDCS_MSB:`CONV_CTRL_SDCS_LSB]);
			clock_out_rate_o <= converter_control[6:5];
		end
	end
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!resetn_i);
	AST_CAL_READY_HIGH: assert property (cal_start_o |-> conversion_ready_n_o)
		else $error("ready low at calibration start");
	AST_CAL_HOLD: assert property ((mode == adc_cmd_pkg::MODE_CAL_RUN) |=> conversion_ready_n_o)
		else $error("ready fell while calibrating");
	AST_IGNORE_IN_CAL: assert property (byte_evt && mode == adc_cmd_pkg::MODE_CAL_RUN
		|=> !cal_start_o && mode != adc_cmd_pkg::MODE_STANDBY)
		else $error("command taken during calibration");
	AST_GAIN_UPDATE: assert property (cal_done_i && mode == adc_cmd_pkg::MODE_CAL_RUN
		&& (cal_kind_o == adc_cmd_pkg::CAL_INTERNAL_GAIN
		|| cal_kind_o == adc_cmd_pkg::CAL_EXTERNAL_GAIN)
		|=> full_scale_coefficient == $past(cal_gain_i))
		else $error("gain coefficient not updated");
	AST_OFFSET_UPDATE: assert property (cal_done_i && mode == adc_cmd_pkg::MODE_CAL_RUN
		&& cal_kind_o == adc_cmd_pkg::CAL_EXTERNAL_OFFSET
		|=> offset_coefficient == $past(cal_offset_i)
		&& $stable(full_scale_coefficient))
		else $error("offset coefficient not updated");
	AST_RESET_KEEPS_CLK: assert property (cmd_take && cmd == `CMD_REG_RESET
		|=> rate_select == `RATE_SELECT_RST && $stable(converter_control[6:5])
		&& cont_read_stop_o)
		else $error("register reset wrong");
	AST_READY_MIRROR: assert property (reg_rd_addr_i == `ADDR_STATUS_CONFIG
		|=> reg_rdata_o[0] == $past(conversion_ready_n_o)
		&& reg_rdata_o[7:4] == FACTORY_ID)
		else $error("status bits wrong");
	AST_BUF_FORCE: assert property (|converter_control[4:3] |=> input_buffer_on_o)
		else $error("buffer not forced on");
	AST_SYNC_RESTART: assert property (mode == adc_cmd_pkg::MODE_SYNC_WAIT && edge_evt
		|=> conv_restart_o ##1 converter_enable_o)
		else $error("sync restart missed");
	AST_STANDBY_ENTER: assert property (cmd_take && cmd == `CMD_STANDBY && !cal_cmd
		|=> ##1 standby_o && !converter_enable_o)
		else $error("standby not entered");
	AST_AUTO_CAL: assert property (auto_calibrate_en_go |=> cal_start_o
		&& cal_kind_o == adc_cmd_pkg::CAL_SELF_BOTH)
		else $error("auto calibration missed");
	COV_CAL_DONE: cover property (cal_start_o ##[1:200] (mode == adc_cmd_pkg::MODE_RUN
		&& !conversion_ready_n_o));
	COV_SINGLE_SHOT: cover property (standby_o ##[1:200] conv_restart_o);
	COV_REG_RESET: cover property (cont_read_stop_o);
endmodule
`default_nettype wire

/* rtl/adc_cmd_defs.svh */
// register offsets, field positions, reset values and command codes
// of the converter command handler; included by bare name.
`ifndef ADC_CMD_DEFS_SVH
`define ADC_CMD_DEFS_SVH

`define ADDR_STATUS_CONFIG    4'h0
`define ADDR_INPUT_SELECT     4'h1
`define ADDR_CONVERTER_CTRL   4'h2
`define ADDR_RATE_SELECT      4'h3
`define ADDR_PIN_IO_CONTROL   4'h4
`define ADDR_OFFSET_COEF_LOW  4'h5
`define ADDR_OFFSET_COEF_MID  4'h6
`define ADDR_OFFSET_COEF_HIGH 4'h7
`define ADDR_GAIN_COEF_LOW    4'h8
`define ADDR_GAIN_COEF_MID    4'h9
`define ADDR_GAIN_COEF_HIGH   4'hA

`define STATUS_ORDER_BIT      3
`define STATUS_AUTO_CALIBRATE_EN_BIT       2
`define STATUS_INPUT_BUFFER_EN_BIT      1
`define STATUS_READY_BIT      0
`define STATUS_WMASK          8'h0E
`define STATUS_RST            8'h00

`define INPUT_SELECT_RST      8'h01
`define CONV_CTRL_RST         8'h20
`define CONV_CTRL_WMASK       8'h7F
`define CONV_CTRL_CLK_MASK    8'h60
`define CONV_CTRL_SDCS_MSB    4
`define CONV_CTRL_SDCS_LSB    3
`define CONV_CTRL_GAIN_MSB    2
`define CONV_CTRL_GAIN_LSB    0
`define RATE_SELECT_RST       8'hF0
`define PIN_IO_RST            8'hE0
`define PIN_IO_WMASK          8'h33
`define PIN_IO_FIXED          8'hC0
`define COEF_RST              24'h000000

`define CMD_RESUME_LOW        8'h00
`define CMD_SELF_CAL          8'hF0
`define CMD_SELF_OFFSET_CAL   8'hF1
`define CMD_INTERNAL_GAIN_CAL 8'hF2
`define CMD_EXTERNAL_OFS_CAL  8'hF3
`define CMD_EXTERNAL_GAIN_CAL 8'hF4
`define CMD_SYNC              8'hFC
`define CMD_STANDBY           8'hFD
`define CMD_REG_RESET         8'hFE
`define CMD_RESUME_HIGH       8'hFF

`endif

/* rtl/adc_cmd_pkg.sv */
// types shared by the converter command handler
// assumes nothing of its surroundings
package adc_cmd_pkg;

	typedef enum logic [2:0] {
		MODE_RUN,
		MODE_CAL_RUN,
		MODE_CAL_SETTLE,
		MODE_STANDBY,
		MODE_SYNC_WAIT
	} mode_t;

	typedef enum logic [2:0] {
		CAL_SELF_BOTH,
		CAL_SELF_OFFSET,
		CAL_INTERNAL_GAIN,
		CAL_EXTERNAL_OFFSET,
		CAL_EXTERNAL_GAIN
	} cal_kind_t;

endpackage

/* tb/host_ctrl_model.sv */
// host controller model: drives serial clock, select and data-in
// assumes the converter's active-low ready output on ready_n_i
`timescale 1ns/1ns
`default_nettype none
module host_ctrl_model (
	input  wire logic ready_n_i,
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      din_o
);
	int timeouts;

	initial
	begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		din_o = 1'b0;
		timeouts = 0;
	end

	// one standalone byte, msb first, 12 ns serial clock
	task automatic send_byte(input logic [7:0] b, input bit need_ready);
		int n;
		n = 0;
		while (need_ready && ready_n_i !== 1'b0 && n < 5000)
		begin
			#4;
			n++;
		end
		if (n >= 5000)
			timeouts++;
		cs_n_o = 1'b0;
		#5;
		for (int i = 7; i >= 0; i--)
		begin
			din_o = b[i];
			#6 sclk_o = 1'b1;
			#6 sclk_o = 1'b0;
		end
		#5 cs_n_o = 1'b1;
		// released line: no pull, so show the inverse of the last bit
		din_o = ~din_o;
	endtask

	// serial clock pulses n times; select is left high from the last byte
	task automatic clocks_deselected(input int n);
		repeat (n)
		begin
			#6 sclk_o = 1'b1;
			#6 sclk_o = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// self-checking bench of the converter command handler
// assumes the host model drives the serial pins; bench plays the neighbours
`timescale 1ns/1ns
`default_nettype none
module tb;
	localparam logic [3:0] ID_VAL = 4'h9; // arbitrary value
	logic                   sys_clk, resetn, sclk, cs_n, din, frame_busy;
	logic                   reg_wr, wr_last, conv_done, data_read, cal_done;
	logic [3:0]             addr, rd_addr;
	logic [7:0]             wdata, rdata;
	logic [23:0]            cal_ofs, cal_gain, ofs_exp, gain_exp;
	logic                   ready_n, cal_start, restart, enable, standby, stop;
	logic                   lsb, buf_on;
	logic [1:0]             clk_rate;
	adc_cmd_pkg::cal_kind_t cal_kind;
	int                     failures, checks, evc[3], evs[3];
	logic [7:0]             rst_tab[11];

	adc_calib_standby_cmd_regs #(.FACTORY_ID(ID_VAL)) adc_calib_standby_cmd_regs_i (
		.sys_clk_i(sys_clk), .resetn_i(resetn), .sclk_i(sclk), .cs_n_i(cs_n),
		.din_i(din), .frame_busy_i(frame_busy), .reg_wr_i(reg_wr), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_last_i(wr_last), .reg_rd_addr_i(rd_addr),
		.conv_done_i(conv_done), .data_read_i(data_read), .cal_done_i(cal_done),
		.cal_offset_i(cal_ofs), .cal_gain_i(cal_gain), .reg_rdata_o(rdata),
		.conversion_ready_n_o(ready_n), .cal_start_o(cal_start), .cal_kind_o(cal_kind),
		.conv_restart_o(restart), .converter_enable_o(enable), .standby_o(standby),
		.cont_read_stop_o(stop), .lsb_first_o(lsb), .input_buffer_on_o(buf_on),
		.clock_out_rate_o(clk_rate));

	host_ctrl_model host_ctrl_model_i (.ready_n_i(ready_n), .sclk_o(sclk), .cs_n_o(cs_n),
		.din_o(din));

	initial
		sys_clk = 1'b0;
	always #4 sys_clk = ~sys_clk;

	// one-cycle pulses are counted as they occur
	always @(posedge sys_clk)
	begin
		if (cal_start === 1'b1)
			evc[0]++;
		if (restart === 1'b1)
			evc[1]++;
		if (stop === 1'b1)
			evc[2]++;
	end

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(negedge sys_clk) rd_addr = a;
		@(negedge sys_clk) check(rdata, exp);
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_wr = 1'b1;
		addr = a;
		wdata = d;
		@(negedge sys_clk) reg_wr = 1'b0;
	endtask

	task automatic pulse(input int k);
		@(negedge sys_clk);
		case (k)
			0: conv_done = 1'b1;
			1: data_read = 1'b1;
			2: cal_done = 1'b1;
			default: wr_last = 1'b1;
		endcase
		@(negedge sys_clk);
		{conv_done, data_read, cal_done, wr_last} = 4'h0;
	endtask

	// bounded wait, then compare pulses since the last wait on the same event:
	// a wake pulse may already fire while the host is still shifting its byte
	task automatic wait_ev(input int k, input int exp);
		int s;
		s = evs[k];
		for (int n = 0; n < 200 && evc[k] == s; n++)
			@(negedge sys_clk);
		repeat (4) @(negedge sys_clk);
		check(evc[k] - s, exp);
		evs[k] = evc[k];
	endtask

	task automatic report_and_stop;
		failures += host_ctrl_model_i.timeouts;
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		#300000;
		failures++;
		report_and_stop();
	end

	initial
	begin
		{resetn, frame_busy, reg_wr, wr_last, conv_done, data_read, cal_done} = 7'h00;
		{addr, rd_addr, wdata, cal_ofs, cal_gain} = 64'h0;
		rst_tab = '{{ID_VAL, 4'h1}, 8'h01, 8'h20, 8'hF0, 8'hE0, 8'h00, 8'h00, 8'h00,
			8'h00, 8'h00, 8'h00};
		repeat (6) @(negedge sys_clk);
		resetn = 1'b1;
		check({enable, standby, lsb, buf_on, clk_rate}, 6'h21);
		for (int i = 0; i < 11; i++)
			rd(i[3:0], rst_tab[i]);
		rd(4'hB, 8'h00);
		$display("test reset done");

		wr(4'h0, 8'hFF);
		rd(4'h0, {ID_VAL, 4'hF});
		check({lsb, buf_on}, 2'b11);
		wr(4'h0, 8'h00);
		wr(4'h2, 8'hFF);
		rd(4'h2, 8'h7F);
		check({clk_rate, buf_on}, 3'b111);
		wr(4'h4, 8'hFF);
		rd(4'h4, 8'hF3);
		wr(4'hB, 8'h55);
		rd(4'hB, 8'h00);
		pulse(0);
		rd(4'h0, {ID_VAL, 4'h0});
		host_ctrl_model_i.send_byte(8'hFE, 1'b1);
		wait_ev(2, 1);
		rd(4'h2, 8'h60);
		rd(4'h4, 8'hE0);
		rd(4'h1, 8'h01);
		check({clk_rate, buf_on}, 3'b110);
		pulse(1);
		rd(4'h0, {ID_VAL, 4'h1});
		$display("test registers done");

		for (int k = 0; k < 5; k++)
		begin
			pulse(0);
			host_ctrl_model_i.send_byte(8'hF0 + k[7:0], 1'b1);
			wait_ev(0, 1);
			check(cal_kind, k[23:0]);
			check(ready_n, 1'b1);
			// the host stays silent until ready falls again
			cal_ofs = 24'h10A000 + k[23:0];
			cal_gain = 24'h20B000 + k[23:0];
			pulse(2);
			check(ready_n, 1'b1);
			if (k != 2 && k != 4)
				ofs_exp = cal_ofs;
			if (k != 1 && k != 3)
				gain_exp = cal_gain;
			pulse(0);
			check(ready_n, 1'b0);
			for (int j = 0; j < 3; j++)
			begin
				rd(4'h5 + j[3:0], ofs_exp[8 * j +: 8]);
				rd(4'h8 + j[3:0], gain_exp[8 * j +: 8]);
			end
		end
		$display("test calibration done");

		frame_busy = 1'b1;
		host_ctrl_model_i.send_byte(8'hF0, 1'b1);
		wait_ev(0, 0);
		frame_busy = 1'b0;
		repeat (2)
		begin
			host_ctrl_model_i.send_byte(8'hFD, 1'b1);
			for (int n = 0; n < 50 && standby !== 1'b1; n++)
				@(negedge sys_clk);
			check({standby, enable}, 2'b10);
			host_ctrl_model_i.clocks_deselected(8);
			wait_ev(1, 0);
			check(standby, 1'b1);
			host_ctrl_model_i.send_byte(8'hFF, 1'b0);
			wait_ev(1, 1);
			check({standby, enable}, 2'b01);
			pulse(0);
			check(ready_n, 1'b0);
		end
		$display("test standby done");

		host_ctrl_model_i.send_byte(8'hFC, 1'b0);
		for (int n = 0; n < 50 && enable !== 1'b0; n++)
			@(negedge sys_clk);
		check(enable, 1'b0);
		host_ctrl_model_i.send_byte(8'h00, 1'b0);
		wait_ev(1, 1);
		check(enable, 1'b1);
		$display("test sync done");

		wr(4'h0, 8'h04);
		wr(4'h3, 8'hF0);
		pulse(3);
		wait_ev(0, 0);
		wr(4'h3, 8'h80);
		pulse(3);
		wait_ev(0, 1);
		check(cal_kind, 24'h0);
		// stray byte during calibration must be dropped
		host_ctrl_model_i.send_byte(8'hFD, 1'b0);
		wait_ev(0, 0);
		check({standby, ready_n}, 2'b01);
		pulse(2);
		pulse(0);
		check(ready_n, 1'b0);
		$display("test auto calibration done");
		report_and_stop();
	end
endmodule
`default_nettype wire
